/* design/trc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trc_defs.svh"
module trc_timer
	import trc_pkg::*;
(
	input  wire logic      i_clk_sys,
	input  wire logic      i_arst_n,
	input  wire logic      i_ce,
	input  wire logic      i_ext_osc,
	input  wire logic      i_cmp_out,
	input  wire logic      i_irq_en,
	input  wire logic      i_wr_ctl,
	input  wire trc_byte_t i_wr_data,
	input  wire logic      i_wr_cnt_low,
	input  wire logic      i_wr_cnt_high,
	input  wire logic      i_wr_rld_low,
	input  wire logic      i_wr_rld_high,
	input  wire logic      i_wr_clk_cfg,
	output trc_byte_t      o_timer_control_reg,
	output trc_byte_t      o_count_low_byte,
	output trc_byte_t      o_count_high_byte,
	output trc_byte_t      o_reload_low_byte,
	output trc_byte_t      o_reload_high_byte,
	output logic           o_high_half_system_clock_sel,
	output logic           o_low_half_system_clock_sel,
	output logic           o_irq_req
);
	trc_tick_if tick ();

	logic      cap_rise;
	trc_byte_t cnt_lo_q, cnt_lo_d;
	trc_byte_t cnt_hi_q, cnt_hi_d;
	trc_byte_t rld_lo_q, rld_lo_d;
	trc_byte_t rld_hi_q, rld_hi_d;
	trc_byte_t ctl_q, ctl_d;
	logic      hsel_q, hsel_d;
	logic      lsel_q, lsel_d;
	logic      irq_q, irq_d;

	trc_tick_gen u_tick (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_ce      (i_ce),
		.i_ext_osc (i_ext_osc),
		.tick      (tick)
	);

	trc_cap_sync u_cap (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_ce      (i_ce),
		.i_cmp_out (i_cmp_out),
		.o_rise    (cap_rise)
	);

	// map a decoded source onto the tick that advances a half
	function automatic logic src_tick(input trc_src_e src, input logic t12,
		input logic t8);
		unique case (src)
			TRC_SRC_SYS:   return 1'b1;
			TRC_SRC_DIV12: return t12;
			TRC_SRC_EXT8:  return t8;
			default:       return 1'b0;
		endcase
	endfunction

	logic split;
	logic capture;
	logic run;
	logic ext_sel;
	logic tick_lo;
	logic tick_hi;
	logic wrap_lo;
	logic wrap_hi;
	logic wrap_16;
	trc_src_e src_lo;
	trc_src_e src_hi;

	assign split   = ctl_q[`TRC_CTL_SPLIT];
	assign capture = ctl_q[`TRC_CTL_CAPTURE_EN] & ~split;
	assign run     = ctl_q[`TRC_CTL_RUN];
	// capture mode forbids the external tick, it falls back to /12
	assign ext_sel = ctl_q[`TRC_CTL_EXT_SEL] & ~capture;
	assign src_lo  = trc_decode_src(lsel_q, ext_sel);
	assign src_hi  = trc_decode_src(hsel_q, ext_sel);
	// in 16-bit mode the high-half select clocks the whole counter
	assign tick_lo = split ? src_tick(src_lo, tick.tick_div12,
		tick.tick_ext8) : (run & src_tick(src_hi, tick.tick_div12,
		tick.tick_ext8));
	assign tick_hi = run & src_tick(src_hi, tick.tick_div12,
		tick.tick_ext8);
	assign wrap_lo = i_ce & tick_lo & (cnt_lo_q == `TRC_BYTE_MAX);
	assign wrap_hi = i_ce & tick_hi & (cnt_hi_q == `TRC_BYTE_MAX);
	assign wrap_16 = ~split & wrap_lo & (cnt_hi_q == `TRC_BYTE_MAX);

	// counting, reload, capture and flag logic
	always_comb begin
		cnt_lo_d = cnt_lo_q;
		cnt_hi_d = cnt_hi_q;
		rld_lo_d = rld_lo_q;
		rld_hi_d = rld_hi_q;
		ctl_d    = ctl_q;
		hsel_d   = hsel_q;
		lsel_d   = lsel_q;
		irq_d    = 1'b0;
		// control, clock and reload writes first, so hardware events below win over them
		if (i_wr_ctl) begin
			ctl_d = i_wr_data;
			ctl_d[1] = 1'b0; // read-only bit
		end
		if (i_wr_clk_cfg) begin
			hsel_d = i_wr_data[5];
			lsel_d = i_wr_data[4];
		end
		if (i_wr_rld_low) begin
			rld_lo_d = i_wr_data;
		end
		if (i_wr_rld_high) begin
			rld_hi_d = i_wr_data;
		end
		if (split) begin
			if (tick_lo) begin
				cnt_lo_d = wrap_lo ? rld_lo_q : cnt_lo_q + 8'h01;
			end
			if (tick_hi) begin
				cnt_hi_d = wrap_hi ? rld_hi_q : cnt_hi_q + 8'h01;
			end
			if (wrap_hi) begin
				ctl_d[`TRC_CTL_HIGH_OVF] = 1'b1;
				irq_d = i_irq_en;
			end
			if (wrap_lo) begin
				ctl_d[`TRC_CTL_LOW_OVF] = 1'b1;
				irq_d = irq_d | (i_irq_en & ctl_q[`TRC_CTL_LOW_IRQ_EN]);
			end
		end else if (tick_lo) begin
			if (wrap_16) begin
				cnt_lo_d = rld_lo_q;
				cnt_hi_d = rld_hi_q;
				ctl_d[`TRC_CTL_HIGH_OVF] = 1'b1;
				irq_d = i_irq_en;
			end else begin
				{cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
				if (wrap_lo) begin
					ctl_d[`TRC_CTL_LOW_OVF] = 1'b1;
					irq_d = i_irq_en & ctl_q[`TRC_CTL_LOW_IRQ_EN];
				end
			end
		end
		// direct count writes take priority over counting
		if (i_wr_cnt_low) begin
			cnt_lo_d = i_wr_data;
		end
		if (i_wr_cnt_high) begin
			cnt_hi_d = i_wr_data;
		end
		if (capture && cap_rise) begin
			rld_lo_d = cnt_lo_q;
			rld_hi_d = cnt_hi_q;
			ctl_d[`TRC_CTL_HIGH_OVF] = 1'b1;
			irq_d = i_irq_en;
		end
		// flags are never cleared here; only software writes drop them
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_lo_q <= `TRC_BYTE_RESET;
			cnt_hi_q <= `TRC_BYTE_RESET;
			rld_lo_q <= `TRC_BYTE_RESET;
			rld_hi_q <= `TRC_BYTE_RESET;
			ctl_q    <= `TRC_BYTE_RESET;
			hsel_q   <= 1'b0;
			lsel_q   <= 1'b0;
			irq_q    <= 1'b0;
		end else if (i_ce) begin
			cnt_lo_q <= cnt_lo_d;
			cnt_hi_q <= cnt_hi_d;
			rld_lo_q <= rld_lo_d;
			rld_hi_q <= rld_hi_d;
			ctl_q    <= ctl_d;
			hsel_q   <= hsel_d;
			lsel_q   <= lsel_d;
			irq_q    <= irq_d;
		end
	end

	assign o_timer_control_reg    = ctl_q;
	assign o_count_low_byte       = cnt_lo_q;
	assign o_count_high_byte      = cnt_hi_q;
	assign o_reload_low_byte      = rld_lo_q;
	assign o_reload_high_byte     = rld_hi_q;
	assign o_high_half_system_clock_sel = hsel_q;
	assign o_low_half_system_clock_sel  = lsel_q;
	assign o_irq_req              = irq_q;
endmodule
`default_nettype wire

/* design/trc_defs.svh */
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH
// control register bit positions
`define TRC_CTL_HIGH_OVF      7
`define TRC_CTL_LOW_OVF       6
`define TRC_CTL_LOW_IRQ_EN    5
`define TRC_CTL_CAPTURE_EN    4
`define TRC_CTL_SPLIT         3
`define TRC_CTL_RUN           2
`define TRC_CTL_EXT_SEL       0
// clock dividers
`define TRC_SYS_DIV           12
`define TRC_EXT_DIV           8
`define TRC_BYTE_RESET        8'h00
`define TRC_BYTE_MAX          8'hFF
`endif

/* design/trc_pkg.sv */
package trc_pkg;
	typedef logic [7:0] trc_byte_t;
	typedef enum logic [2:0] {
		TRC_SRC_SYS   = 3'b001,
		TRC_SRC_DIV12 = 3'b010,
		TRC_SRC_EXT8  = 3'b100
	} trc_src_e;
	// pick the tick source of one half from its own and the shared select
	function automatic trc_src_e trc_decode_src(input logic sys_sel,
		input logic ext_sel);
		if (sys_sel) begin
			return TRC_SRC_SYS;
		end
		return ext_sel ? TRC_SRC_EXT8 : TRC_SRC_DIV12;
	endfunction
endpackage

/* design/trc_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// prescaler ticks shared between the tick generator and the counter
interface trc_tick_if;
	logic tick_div12;
	logic tick_ext8;
	modport src (output tick_div12, output tick_ext8);
	modport dst (input tick_div12, input tick_ext8);
endinterface
`default_nettype wire

/* design/trc_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trc_defs.svh"
module trc_tick_gen
	import trc_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	input  wire logic i_ce,
	input  wire logic i_ext_osc,
	trc_tick_if.src   tick
);
	logic [3:0] div12_q, div12_d;
	logic [2:0] ext_sync_q, ext_sync_d;
	logic [2:0] ext_cnt_q, ext_cnt_d;
	logic       ext_tick_q, ext_tick_d;
	logic       tick12_q, tick12_d;

	// divide by 12 and count external edges; ext_sync_q[0] feeds only [1]
	always_comb begin
		div12_d    = div12_q;
		tick12_d   = 1'b0;
		ext_sync_d = {ext_sync_q[1:0], i_ext_osc};
		ext_cnt_d  = ext_cnt_q;
		ext_tick_d = 1'b0;
		if (div12_q == 4'(`TRC_SYS_DIV - 1)) begin
			div12_d  = 4'h0;
			tick12_d = 1'b1;
		end else begin
			div12_d = div12_q + 4'h1;
		end
		// count rising edges only: eight oscillator periods make one tick
		if (ext_sync_q[1] & ~ext_sync_q[2]) begin
			ext_cnt_d = ext_cnt_q + 3'h1;
			if (ext_cnt_q == 3'(`TRC_EXT_DIV - 1)) begin
				ext_tick_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div12_q    <= 4'h0;
			tick12_q   <= 1'b0;
			ext_sync_q <= 3'h0;
			ext_cnt_q  <= 3'h0;
			ext_tick_q <= 1'b0;
		end else if (i_ce) begin
			div12_q    <= div12_d;
			tick12_q   <= tick12_d;
			ext_sync_q <= ext_sync_d;
			ext_cnt_q  <= ext_cnt_d;
			ext_tick_q <= ext_tick_d;
		end
	end

	assign tick.tick_div12 = tick12_q;
	assign tick.tick_ext8  = ext_tick_q;
endmodule
`default_nettype wire

/* design/trc_cap_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_cap_sync
	import trc_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	input  wire logic i_ce,
	input  wire logic i_cmp_out,
	output logic      o_rise
);
	logic [2:0] sync_q, sync_d;

	// two stages before the edge detector, third stage is the old value
	always_comb begin
		sync_d = {sync_q[1:0], i_cmp_out};
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_q <= 3'h0;
		end else if (i_ce) begin
			sync_q <= sync_d;
		end
	end

	// one pulse per synchronised rising edge
	assign o_rise = i_ce & sync_q[1] & ~sync_q[2];
endmodule
`default_nettype wire

/* dv/trc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_partner (
	input  wire logic i_clk_sys,
	input  wire logic i_irq_req,
	output var logic  o_cmp_out
);
	int irq_cnt = 0;
	initial o_cmp_out = 1'b0;
	// interrupt side tallies each one-cycle request
	always @(posedge i_clk_sys) begin
		if (i_irq_req === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	// edges kept far slower than the timer clock for a clean reading
	task automatic cmp_pulse();
		o_cmp_out = 1'b1;
		repeat (8) @(negedge i_clk_sys);
		o_cmp_out = 1'b0;
		repeat (8) @(negedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

/* dv/trc_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_timer_sva
	import trc_pkg::*;
(
	input wire logic      i_clk_sys,
	input wire logic      i_arst_n,
	input wire logic      i_ce,
	input wire logic      i_cmp_out,
	input wire logic      i_irq_en,
	input wire logic      i_wr_ctl,
	input wire logic      i_wr_cnt_low,
	input wire logic      i_wr_cnt_high,
	input wire logic      i_wr_rld_low,
	input wire logic      i_wr_rld_high,
	input wire logic      i_wr_clk_cfg,
	input wire trc_byte_t o_timer_control_reg,
	input wire trc_byte_t o_count_low_byte,
	input wire trc_byte_t o_count_high_byte,
	input wire trc_byte_t o_reload_low_byte,
	input wire trc_byte_t o_reload_high_byte,
	input wire logic      o_high_half_system_clock_sel,
	input wire logic      o_low_half_system_clock_sel,
	input wire logic      o_irq_req
);
	// shorthands; any write strobe voids the counting relations
	wire trc_byte_t   c = o_timer_control_reg;
	wire logic [15:0] cnt = {o_count_high_byte, o_count_low_byte};
	wire logic [15:0] rld = {o_reload_high_byte, o_reload_low_byte};
	wire logic wr = i_wr_ctl | i_wr_cnt_low | i_wr_cnt_high | i_wr_rld_low
		| i_wr_rld_high | i_wr_clk_cfg;
	wire logic run16 = i_ce & !c[3] & c[2] & !c[4] & o_high_half_system_clock_sel
		& !wr;
	wire logic lo_t = i_ce & c[3] & o_low_half_system_clock_sel & !wr;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	property p_flag_keep; $fell(c[7]) |-> $past(i_wr_ctl); endproperty
	a_flag_keep: assert property (p_flag_keep)
		else $error("high flag dropped without a write");
	property p_wrap16;
		run16 && cnt == 16'hFFFF |=> cnt == $past(rld) && c[7];
	endproperty
	a_wrap16: assert property (p_wrap16)
		else $error("16-bit wrap did not reload");
	property p_irq16; run16 && cnt == 16'hFFFF && i_irq_en |=> o_irq_req;
	endproperty
	a_irq16: assert property (p_irq16)
		else $error("no request on 16-bit wrap");
	property p_low_run;
		lo_t && cnt[7:0] != 8'hFF |=> cnt[7:0] == $past(cnt[7:0]) + 8'h01;
	endproperty
	a_low_run: assert property (p_low_run)
		else $error("split low half not counting");
	property p_low_wrap;
		lo_t && cnt[7:0] == 8'hFF |=> cnt[7:0] == $past(rld[7:0]) && c[6];
	endproperty
	a_low_wrap: assert property (p_low_wrap)
		else $error("split low wrap wrong");
	property p_irq_low;
		lo_t && cnt[7:0] == 8'hFF && c[5] && i_irq_en |=> o_irq_req;
	endproperty
	a_irq_low: assert property (p_irq_low)
		else $error("no request on low wrap");
	property p_high_stop; c[3] && !c[2] && !wr |=> $stable(cnt[15:8]);
	endproperty
	a_high_stop: assert property (p_high_stop)
		else $error("stopped high half moved");
	property p_capture;
		c[4] && !c[3] && i_ce && !wr && $rose(i_cmp_out) |-> ##[2:5] c[7];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture flag missing");
	c_wrap16: cover property (run16 && cnt == 16'hFFFF);
	c_low_wrap: cover property (lo_t && cnt[7:0] == 8'hFF);
	c_cap: cover property (o_irq_req && c[4]);
endmodule
bind trc_timer trc_timer_sva trc_timer_sva_inst (.*);
`default_nettype wire

/* dv/timer2_reload_capture_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module timer2_reload_capture_tb;
	import trc_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ext = 1'b0;
	logic       ce = 1'b1;
	logic       irq_en = 1'b1;
	logic [5:0] ws = 6'h00; // ctl, cnt lo, cnt hi, rld lo, rld hi, clk cfg
	trc_byte_t  wd = 8'h00;
	trc_byte_t  ctl, clo, chi, rlo, rhi;
	trc_byte_t  sv;
	logic       hs, ls, irq, cmp;
	int         num_errors = 0;
	int         cmp_count = 0;
	int         n;
	trc_timer trc_timer_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_ce(ce),
		.i_ext_osc(ext), .i_cmp_out(cmp), .i_irq_en(irq_en),
		.i_wr_ctl(ws[0]), .i_wr_data(wd), .i_wr_cnt_low(ws[1]),
		.i_wr_cnt_high(ws[2]), .i_wr_rld_low(ws[3]), .i_wr_rld_high(ws[4]),
		.i_wr_clk_cfg(ws[5]), .o_timer_control_reg(ctl),
		.o_count_low_byte(clo), .o_count_high_byte(chi),
		.o_reload_low_byte(rlo), .o_reload_high_byte(rhi),
		.o_high_half_system_clock_sel(hs), .o_low_half_system_clock_sel(ls),
		.o_irq_req(irq));
	trc_partner trc_partner_inst (.i_clk_sys(clk), .i_irq_req(irq),
		.o_cmp_out(cmp));
	initial forever #50 clk = ~clk;
	// oscillator left unrelated in phase to the system clock
	always #370 ext = ~ext;
	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one cycle of strobe, then a gap so strobes never retrigger at once
	task automatic wr(int k, trc_byte_t d);
		ws[k] = 1'b1;
		wd = d;
		@(negedge clk);
		ws = 6'h00;
		@(negedge clk);
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_wrap16;
		wr(5, 8'h30); wr(3, 8'h34); wr(4, 8'h12); wr(2, 8'hFE); wr(1, 8'hFE);
		chk("count split", {chi, clo}, 16'hFEFE);
		chk("clk cfg", {hs, ls}, 2'b11);
		n = trc_partner_inst.irq_cnt;
		wr(0, 8'h24);
		for (int i = 0; i < 400 && ctl[7] !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		chk("flags", ctl[7:6], 2'b11);
		chk("high reload", chi, 8'h12);
		chk("irq 16", trc_partner_inst.irq_cnt - n, 2);
		$display("wrap16 done");
	endtask
	task automatic t_split;
		wr(0, 8'h29); wr(5, 8'h10); wr(3, 8'h00); wr(4, 8'hA0);
		wr(2, 8'hFF); wr(1, 8'hF0);
		n = trc_partner_inst.irq_cnt;
		repeat (20) @(negedge clk);
		chk("high held", chi, 8'hFF);
		chk("low flag", ctl[7:6], 2'b01);
		chk("irq low", trc_partner_inst.irq_cnt - n, 1);
		wr(0, 8'h2D);
		for (int i = 0; i < 100 && ctl[7] !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		chk("high flag", ctl[7:6], 2'b10);
		chk("high reload", chi[7:4], 4'hA);
		$display("split done");
	endtask
	task automatic t_capture;
		wr(0, 8'h10); wr(2, 8'h9A); wr(1, 8'hBC);
		n = trc_partner_inst.irq_cnt;
		trc_partner_inst.cmp_pulse();
		chk("captured", {rhi, rlo}, 16'h9ABC);
		chk("cap flag", ctl[7], 1'b1);
		chk("cap irq", trc_partner_inst.irq_cnt - n, 1);
		wr(0, 8'h18); wr(1, 8'h11);
		trc_partner_inst.cmp_pulse();
		chk("no capture", {rhi, rlo}, 16'h9ABC);
		// clock enable low must freeze the free-running low half
		sv = clo;
		ce = 1'b0;
		repeat (5) @(negedge clk);
		chk("frozen", clo, sv);
		ce = 1'b1;
		// capture mode ignores the external select and ticks at /12
		wr(5, 8'h00); wr(0, 8'h15); wr(2, 8'h00); wr(1, 8'h00);
		repeat (120) @(negedge clk);
		n = {chi, clo};
		chk("div12 count", n >= 9 && n <= 11, 1);
		$display("capture done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("reset ctl", ctl, 8'h00);
		chk("reset count", {chi, clo}, 16'h0000);
		t_wrap16;
		t_split;
		t_capture;
		test_done;
	end
	initial begin
		#500000;
		num_errors++;
		test_done;
	end
endmodule
`default_nettype wire
